//--- psc_top.sv
// Function
// - fetch and program stream block by block
// - authenticate stream, verify contents before completion
// - security applied after erase or at end
// - device reset after successful programming
// - count increments on program and erase
// - verify previous block while loading next
// - active during init, then re-suspend
// - suspend bit written only by stream
// - suspended: held in reset, no services
// - release pin high lifts suspend temporarily
// - suspend enabled, release low blocks jtag commands; scan data still reaches the scan bus
// - suspend enabled: no spi master programming
// - suspend enabled: later service requests unserved
// - suspend enabled: no tamper flags raised
// - suspend enabled: no tamper reset or zeroize
// - command register plus 128-bit data buffer
// - scan mode: test data in is bit zero
// - spi role latched during init (after reset or successful programming), then fixed
`timescale 1ns/100ps
module psc_top
  import psc_pkg::*;
(
  input wire logic CLK_SYS, // 100 MHz test-side clock
  input wire logic RESET_N, // power-on or hard reset, active low
  input wire logic TEST_RESET_SUSPEND_RELEASE, // pin, high lifts suspend
  input wire logic SPI_ROLE_SELECT, // pin, 1 = spi master role
  input wire logic NV_SUSPEND_CELL, // non-volatile suspend-enable cell
  output logic NV_SUSPEND_WR, // write strobe to the cell
  output logic NV_SUSPEND_WDATA, // value written to the cell
  input wire logic CMD_VALID, // command register loaded
  output logic CMD_READY, // command register taken
  input wire logic [7:0] CMD_OPCODE, // instruction
  input wire logic [2:0] CMD_SRC, // origin of the instruction
  input wire logic BUF_VALID, // data buffer holds a block
  output logic BUF_READY, // data buffer taken
  input wire logic [BUF_W-1:0] BUF_DATA, // 128-bit data buffer
  input wire logic BUF_LAST, // last block of the stream
  output logic MEM_WR, // config memory write strobe
  output logic [ADDR_W-1:0] MEM_ADDR, // write block address
  output logic [BUF_W-1:0] MEM_WDATA, // write block data
  output logic MEM_RD, // readback strobe
  output logic [ADDR_W-1:0] MEM_RADDR, // readback block address
  input wire logic [BUF_W-1:0] MEM_RDATA, // readback data, cycle after MEM_RD
  output logic MEM_ERASE, // erase pass strobe
  output logic SEC_WR, // security settings write strobe
  output logic [SEC_W-1:0] SEC_DATA, // security settings
  output logic DEV_RESET, // device reset pulse
  output logic PROG_DONE, // operation completed pulse
  output logic PROG_ERR, // verify or authentication failure pulse
  output logic [CNT_W-1:0] PROG_COUNT, // programming cycle count
  output logic CTRL_HELD_RESET, // controller held in reset (suspended)
  input wire logic SVC_REQ, // system service request
  output logic SVC_ACK, // service served pulse
  input wire logic TAMPER_EVT, // tamper detector event
  input wire logic TAMPER_ZEROIZE_SEL, // response: 1 zeroize, 0 reset
  output logic TAMPER_FLAG, // tamper flag pulse
  output logic TAMPER_RESP_RESET, // tamper reset response pulse
  output logic TAMPER_RESP_ZEROIZE, // tamper zeroize response pulse
  input wire logic SCAN_MODE, // scan test with wide data bus
  input wire logic TDI, // standard test data in
  input wire logic [2:0] SCAN_TDI_HI, // upper scan data inputs
  output logic [3:0] SCAN_TDI_BUS // assembled scan data bus
);
  typedef struct packed {
    psc_state_e st;
    logic [3:0] init_cnt;
    logic init_done;
    logic susp_en;
    logic role_master;
    logic sec_at_erase;
    logic nv_new;
    logic erase_only;
    logic have_prev;
    logic last;
    logic [SEC_W-1:0] sec_val;
    logic [DIG_W-1:0] exp_dig;
    logic [DIG_W-1:0] dig;
    logic [ADDR_W-1:0] addr;
    logic [BUF_W-1:0] prev;
    logic mem_wr;
    logic mem_rd;
    logic mem_erase;
    logic [ADDR_W-1:0] raddr;
    logic [BUF_W-1:0] wdata;
    logic sec_wr;
    logic nv_wr;
    logic dev_reset;
    logic done;
    logic err;
    logic cnt_inc;
    logic svc_ack;
    logic tamper_flag;
    logic tamper_rst;
    logic tamper_zero;
    logic [3:0] tdi_bus;
  } psc_regs_s;
  psc_regs_s r_q, r_d;

  logic [SYNC_N-1:0] pin_raw, pin_sync;
  logic release_s, role_s, active, cmd_take, buf_take;

  // fold a block into the running stream digest
  function automatic logic [DIG_W-1:0] fold(input logic [BUF_W-1:0] b);
    fold = b[31:0] ^ b[63:32] ^ b[95:64] ^ b[127:96];
  endfunction

  // may a request from this origin run under the present settings
  function automatic logic src_ok(input logic [2:0] src, input logic susp,
                                  input logic master);
    if (src == SRC_JTAG)
    begin
      src_ok = 1'b1;
    end
    else if (src == SRC_SPI_SLAVE)
    begin
      src_ok = !master;
    end
    else if ((src == SRC_SPI_MASTER) || (src == SRC_APP_UPDATE) || (src == SRC_AUTO_UPDATE))
    begin
      src_ok = master && !susp;
    end
    else
    begin
      src_ok = 1'b0;
    end
  endfunction

  // both pins come from the board, so each gets the three-stage filter
  assign pin_raw = {SPI_ROLE_SELECT, TEST_RESET_SUSPEND_RELEASE};
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_N; gi++)
    begin : g_sync
      psc_sync u_sync (
        .clk(CLK_SYS),
        .rst_n(RESET_N),
        .d(pin_raw[gi]),
        .q(pin_sync[gi])
      );
    end
  endgenerate
  assign release_s = pin_sync[0];
  assign role_s = pin_sync[1];

  psc_cnt u_cnt (
    .clk(CLK_SYS),
    .rst_n(RESET_N),
    .inc(r_q.cnt_inc),
    .count(PROG_COUNT)
  );

  // controller runs during init, else only if suspend is off or released
  assign active = !r_q.susp_en || !r_q.init_done || release_s;
  // requests are drained in idle and in suspend; while suspended they are dropped unseen
  assign CMD_READY = (r_q.st == ST_IDLE) || (r_q.st == ST_SUSP);
  assign cmd_take = CMD_VALID && CMD_READY;
  assign BUF_READY = (r_q.st == ST_HDR) || (r_q.st == ST_FETCH);
  assign buf_take = BUF_VALID && BUF_READY;

  // sequencer
  always_comb
  begin
    r_d = r_q;
    r_d.mem_wr = 1'b0;
    r_d.mem_rd = 1'b0;
    r_d.mem_erase = 1'b0;
    r_d.sec_wr = 1'b0;
    r_d.nv_wr = 1'b0;
    r_d.dev_reset = 1'b0;
    r_d.done = 1'b0;
    r_d.err = 1'b0;
    r_d.cnt_inc = 1'b0;
    r_d.svc_ack = 1'b0;
    r_d.tamper_flag = 1'b0;
    r_d.tamper_rst = 1'b0;
    r_d.tamper_zero = 1'b0;
    r_d.tdi_bus = SCAN_MODE ? {SCAN_TDI_HI, TDI} : 4'h0;
    // tamper handling is silenced outright while suspend is enabled
    if (TAMPER_EVT && !r_q.susp_en && r_q.init_done)
    begin
      r_d.tamper_flag = 1'b1;
      r_d.tamper_rst = !TAMPER_ZEROIZE_SEL;
      r_d.tamper_zero = TAMPER_ZEROIZE_SEL;
    end
    case (r_q.st)
      ST_INIT:
      begin
        // role and suspend bit are caught here only, never later
        r_d.role_master = role_s;
        r_d.susp_en = NV_SUSPEND_CELL;
        r_d.init_cnt = r_q.init_cnt + 4'h1;
        if (r_q.init_cnt == INIT_LAST)
        begin
          r_d.init_done = 1'b1;
          r_d.st = (r_q.susp_en && !release_s) ? ST_SUSP : ST_IDLE;
        end
      end
      ST_SUSP:
      begin
        if (release_s)
        begin
          r_d.st = ST_IDLE;
        end
      end
      ST_IDLE:
      begin
        if (SVC_REQ && !r_q.susp_en)
        begin
          r_d.svc_ack = 1'b1;
        end
        if (cmd_take && src_ok(CMD_SRC, r_q.susp_en, r_q.role_master))
        begin
          if (CMD_OPCODE == OP_PROGRAM)
          begin
            r_d.st = ST_HDR;
            r_d.erase_only = 1'b0;
          end
          else if (CMD_OPCODE == OP_ERASE)
          begin
            r_d.st = ST_ERASE;
            r_d.erase_only = 1'b1;
          end
        end
      end
      ST_HDR:
      begin
        if (buf_take)
        begin
          r_d.sec_at_erase = BUF_DATA[HDR_SEC_AT_ERASE];
          r_d.nv_new = BUF_DATA[HDR_SUSPEND_EN];
          r_d.sec_val = BUF_DATA[HDR_SEC_LSB +: SEC_W];
          r_d.exp_dig = BUF_DATA[HDR_DIG_LSB +: DIG_W];
          r_d.st = ST_ERASE;
        end
      end
      ST_ERASE:
      begin
        // erase is itself a programming pass and is counted as one
        r_d.mem_erase = 1'b1;
        r_d.cnt_inc = 1'b1;
        r_d.addr = '0;
        r_d.dig = '0;
        r_d.have_prev = 1'b0;
        if (r_q.erase_only)
        begin
          r_d.done = 1'b1;
          r_d.st = ST_IDLE;
        end
        else
        begin
          r_d.sec_wr = r_q.sec_at_erase;
          r_d.st = ST_FETCH;
        end
      end
      ST_FETCH:
      begin
        if (buf_take)
        begin
          r_d.mem_wr = 1'b1;
          r_d.wdata = BUF_DATA;
          r_d.mem_rd = r_q.have_prev;
          r_d.raddr = r_q.addr - 16'h0001;
          r_d.dig = r_q.dig ^ fold(BUF_DATA);
          r_d.last = BUF_LAST;
          r_d.st = ST_WRITE;
        end
      end
      ST_WRITE:
      begin
        r_d.st = ST_CMP;
      end
      ST_CMP:
      begin
        if (r_q.have_prev && (MEM_RDATA != r_q.prev))
        begin
          r_d.err = 1'b1;
          r_d.st = ST_IDLE;
        end
        else
        begin
          r_d.prev = r_q.wdata;
          r_d.have_prev = 1'b1;
          r_d.addr = r_q.addr + 16'h0001;
          r_d.st = r_q.last ? ST_FVFY : ST_FETCH;
          r_d.mem_rd = r_q.last;
          r_d.raddr = r_q.addr;
        end
      end
      ST_FVFY:
      begin
        r_d.st = ST_FCHK;
      end
      ST_FCHK:
      begin
        r_d.st = (MEM_RDATA == r_q.prev) ? ST_AUTH : ST_IDLE;
        r_d.err = (MEM_RDATA != r_q.prev);
      end
      ST_AUTH:
      begin
        if (r_q.dig == r_q.exp_dig)
        begin
          r_d.cnt_inc = 1'b1;
          r_d.sec_wr = !r_q.sec_at_erase;
          r_d.nv_wr = 1'b1;
          r_d.dev_reset = 1'b1;
          r_d.done = 1'b1;
          r_d.init_done = 1'b0;
          r_d.init_cnt = '0;
          r_d.st = ST_INIT;
        end
        else
        begin
          r_d.err = 1'b1;
          r_d.st = ST_IDLE;
        end
      end
      default:
      begin
        r_d.st = ST_INIT;
      end
    endcase
    // losing the release pin mid-run drops straight back into suspend
    if (!active && (r_q.st != ST_INIT))
    begin
      r_d.st = ST_SUSP;
      r_d.mem_wr = 1'b0;
      r_d.mem_rd = 1'b0;
      r_d.mem_erase = 1'b0;
      r_d.sec_wr = 1'b0;
      r_d.nv_wr = 1'b0;
      r_d.cnt_inc = 1'b0;
      r_d.svc_ack = 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      r_q <= '0;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  // registered outputs
  assign NV_SUSPEND_WR = r_q.nv_wr;
  assign NV_SUSPEND_WDATA = r_q.nv_new;
  assign MEM_WR = r_q.mem_wr;
  assign MEM_ADDR = r_q.addr;
  assign MEM_WDATA = r_q.wdata;
  assign MEM_RD = r_q.mem_rd;
  assign MEM_RADDR = r_q.raddr;
  assign MEM_ERASE = r_q.mem_erase;
  assign SEC_WR = r_q.sec_wr;
  assign SEC_DATA = r_q.sec_val;
  assign DEV_RESET = r_q.dev_reset;
  assign PROG_DONE = r_q.done;
  assign PROG_ERR = r_q.err;
  assign CTRL_HELD_RESET = (r_q.st == ST_SUSP);
  assign SVC_ACK = r_q.svc_ack;
  assign TAMPER_FLAG = r_q.tamper_flag;
  assign TAMPER_RESP_RESET = r_q.tamper_rst;
  assign TAMPER_RESP_ZEROIZE = r_q.tamper_zero;
  assign SCAN_TDI_BUS = r_q.tdi_bus;

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESET_N);

  block_write_a: assert property ((r_q.st == ST_FETCH) && buf_take && active |=>
    MEM_WR && (MEM_WDATA == $past(BUF_DATA)))
    else $error("accepted block not written");
  reset_source_a: assert property (DEV_RESET |-> $past(r_q.st) == ST_AUTH
    && $past(r_q.dig) == $past(r_q.exp_dig))
    else $error("device reset without authentication");
  sec_timing_a: assert property (SEC_WR |->
    ($past(r_q.st) == ST_ERASE) || ($past(r_q.st) == ST_AUTH))
    else $error("security written outside erase or end");
  auth_reset_a: assert property ((r_q.st == ST_AUTH) && (r_q.dig == r_q.exp_dig) && active
    |=> DEV_RESET ##1 (r_q.st == ST_INIT))
    else $error("no device reset after success");
  erase_count_a: assert property (MEM_ERASE && (PROG_COUNT != CNT_MAX) |=>
    PROG_COUNT == $past(PROG_COUNT) + 16'h0001)
    else $error("erase not counted");
  overlap_vfy_a: assert property (MEM_WR && r_q.have_prev |->
    MEM_RD && (MEM_RADDR == MEM_ADDR - 16'h0001))
    else $error("previous block not verified with load");
  resuspend_a: assert property ((r_q.st == ST_INIT) && (r_q.init_cnt == INIT_LAST)
    && r_q.susp_en && !release_s |=> CTRL_HELD_RESET)
    else $error("no suspend after init");
  susp_quiet_a: assert property (CTRL_HELD_RESET |-> !MEM_WR && !MEM_ERASE
    && !SVC_ACK && !SEC_WR && !NV_SUSPEND_WR)
    else $error("activity while suspended");
  stay_susp_a: assert property (CTRL_HELD_RESET && !release_s |=> CTRL_HELD_RESET)
    else $error("left suspend without release");
  master_block_a: assert property ((r_q.st == ST_IDLE) && cmd_take && r_q.susp_en
    && (CMD_SRC == SRC_SPI_MASTER) |=> (r_q.st == ST_IDLE) || CTRL_HELD_RESET)
    else $error("spi master ran under suspend");
  tamper_off_a: assert property (r_q.susp_en |->
    !TAMPER_FLAG && !TAMPER_RESP_RESET && !TAMPER_RESP_ZEROIZE)
    else $error("tamper action under suspend");
  scan_bit0_a: assert property (SCAN_MODE |=> SCAN_TDI_BUS[0] == $past(TDI))
    else $error("scan bus bit zero not test data in");
  role_hold_a: assert property (r_q.init_done |=> $stable(r_q.role_master))
    else $error("spi role changed after init");

  prog_pass_c: cover property (DEV_RESET);
  erase_only_c: cover property ((r_q.st == ST_ERASE) && r_q.erase_only);
  release_c: cover property (CTRL_HELD_RESET ##1 (r_q.st == ST_IDLE));
  verify_fail_c: cover property (PROG_ERR);
endmodule

//--- psc_pkg.sv
package psc_pkg;
  // command opcodes placed in the command register by the jtag controller
  localparam logic [7:0] OP_PROGRAM = 8'h01;
  localparam logic [7:0] OP_ERASE = 8'h02;
  // origin of a request
  localparam logic [2:0] SRC_JTAG = 3'h0;
  localparam logic [2:0] SRC_SPI_SLAVE = 3'h1;
  localparam logic [2:0] SRC_SPI_MASTER = 3'h2;
  localparam logic [2:0] SRC_APP_UPDATE = 3'h3;
  localparam logic [2:0] SRC_AUTO_UPDATE = 3'h4;
  // widths
  localparam int BUF_W = 128;
  localparam int ADDR_W = 16;
  localparam int SEC_W = 32;
  localparam int DIG_W = 32;
  localparam int CNT_W = 16;
  localparam int SYNC_N = 2;
  // header block field positions
  localparam int HDR_SEC_AT_ERASE = 0;
  localparam int HDR_SUSPEND_EN = 1;
  localparam int HDR_SEC_LSB = 8;
  localparam int HDR_DIG_LSB = 96;
  // last initialisation cycle count; init lasts 16 clock cycles
  localparam logic [3:0] INIT_LAST = 4'hf;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
  // sequencer states, gray coded along the programming path
  typedef enum logic [3:0] {
    ST_INIT = 4'h0,
    ST_IDLE = 4'h1,
    ST_HDR = 4'h3,
    ST_ERASE = 4'h2,
    ST_FETCH = 4'h6,
    ST_WRITE = 4'h7,
    ST_CMP = 4'h5,
    ST_FVFY = 4'h4,
    ST_FCHK = 4'hc,
    ST_AUTH = 4'hd,
    ST_SUSP = 4'h8
  } psc_state_e;
endpackage

//--- psc_sync.sv
`timescale 1ns/100ps
module psc_sync
  import psc_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic d, // pin level
  output logic q // filtered level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } psc_sync_s;
  psc_sync_s r_q, r_d;

  // a change is taken only once the second and third stage agree
  always_comb
  begin
    r_d = r_q;
    r_d.s1 = d;
    r_d.s2 = r_q.s1;
    r_d.s3 = r_q.s2;
    if (r_q.s2 == r_q.s3)
    begin
      r_d.q = r_q.s3;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r_q <= '0;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  assign q = r_q.q;
endmodule

//--- psc_cnt.sv
`timescale 1ns/100ps
module psc_cnt
  import psc_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic inc, // one-cycle increment request
  output logic [CNT_W-1:0] count // programming cycle count
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } psc_cnt_s;
  psc_cnt_s r_q, r_d;

  // saturates so that a worn part never wraps back to a fresh count
  always_comb
  begin
    r_d = r_q;
    if (inc && (r_q.cnt != CNT_MAX))
    begin
      r_d.cnt = r_q.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r_q <= '0;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  assign count = r_q.cnt;
endmodule

//--- psc_mem_model.sv
`timescale 1ns/100ps
// configuration memory beside the sequencer: keeps written blocks, answers readback
module psc_mem_model
  import psc_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic wr, // write strobe
  input wire logic [ADDR_W-1:0] addr, // write block address
  input wire logic [BUF_W-1:0] wdata, // write block data
  input wire logic rd, // readback strobe
  input wire logic [ADDR_W-1:0] raddr, // readback block address
  input wire logic erase, // erase pass strobe
  input wire logic corrupt, // bench order: flip readback bits
  output logic [BUF_W-1:0] rdata // readback data
);
  logic [BUF_W-1:0] mem [logic [ADDR_W-1:0]];
  initial rdata = {BUF_W{1'b0}};
  // readback is only good in the cycle after the strobe; otherwise it churns so
  // a sequencer that samples late sees garbage instead of a stale match
  always @(posedge clk)
  begin
    if (erase)
      mem.delete();
    if (wr)
      mem[addr] = wdata;
    if (rd)
      rdata <= (mem.exists(raddr) ? mem[raddr] : ~wdata) ^ {BUF_W{corrupt}};
    else
      rdata <= ~rdata;
  end
endmodule

//--- psc_top_bench.sv
`timescale 1ns/100ps
`define CHK(a, b) \
  begin n_checks++; if ((a) !== (b)) begin err_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module psc_top_bench
  import psc_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, rel = 1'b0, role = 1'b0, nv_cell = 1'b0, corrupt = 1'b0;
  logic cmd_valid, buf_valid, buf_last, svc_req, tamper_evt, zsel, scan_mode, tdi;
  logic [7:0] op;
  logic [2:0] src, hi;
  logic [BUF_W-1:0] bdata, mem_wdata, mem_rdata;
  logic nv_wr, nv_wdata, cmd_ready, buf_ready, mem_wr, mem_rd, mem_erase, sec_wr, dev_reset;
  logic prog_done, prog_err, held, svc_ack, t_flag, t_rst, t_zero;
  logic [ADDR_W-1:0] mem_addr, mem_raddr;
  logic [SEC_W-1:0] sec_data, sec_cap;
  logic [CNT_W-1:0] count;
  logic [3:0] scan_bus;
  logic [ADDR_W-1:0] addr_q [$];
  int err_count = 0, n_checks = 0;
  int wr_n = 0, er_n = 0, dr_n = 0, dn_n = 0, pe_n = 0, sv_n = 0, tf_n = 0, tr_n = 0;
  int tz_n = 0, sec_at = 0;
  // scan rows {mode, tdi, upper bits, expected bus}
  logic [8:0] scan_rows [4] = '{9'h1db, 9'h124, 9'h0f0, 9'h1ff};
  // command rows {opcode, source, accepted}
  logic [11:0] cmd_rows [6] = '{{OP_ERASE, SRC_JTAG, 1'b1}, {OP_ERASE, SRC_SPI_SLAVE, 1'b1},
    {OP_ERASE, SRC_SPI_MASTER, 1'b0}, {OP_ERASE, SRC_APP_UPDATE, 1'b0},
    {OP_ERASE, SRC_AUTO_UPDATE, 1'b0}, {8'h5a, SRC_JTAG, 1'b0}};

  psc_top dut (.CLK_SYS(clk), .RESET_N(rst_n), .TEST_RESET_SUSPEND_RELEASE(rel),
    .SPI_ROLE_SELECT(role), .NV_SUSPEND_CELL(nv_cell), .NV_SUSPEND_WR(nv_wr),
    .NV_SUSPEND_WDATA(nv_wdata), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready),
    .CMD_OPCODE(op), .CMD_SRC(src), .BUF_VALID(buf_valid), .BUF_READY(buf_ready),
    .BUF_DATA(bdata), .BUF_LAST(buf_last), .MEM_WR(mem_wr), .MEM_ADDR(mem_addr),
    .MEM_WDATA(mem_wdata), .MEM_RD(mem_rd), .MEM_RADDR(mem_raddr), .MEM_RDATA(mem_rdata),
    .MEM_ERASE(mem_erase), .SEC_WR(sec_wr), .SEC_DATA(sec_data), .DEV_RESET(dev_reset),
    .PROG_DONE(prog_done), .PROG_ERR(prog_err), .PROG_COUNT(count), .CTRL_HELD_RESET(held),
    .SVC_REQ(svc_req), .SVC_ACK(svc_ack), .TAMPER_EVT(tamper_evt),
    .TAMPER_ZEROIZE_SEL(zsel), .TAMPER_FLAG(t_flag), .TAMPER_RESP_RESET(t_rst),
    .TAMPER_RESP_ZEROIZE(t_zero), .SCAN_MODE(scan_mode), .TDI(tdi), .SCAN_TDI_HI(hi),
    .SCAN_TDI_BUS(scan_bus));

  psc_mem_model mem_model (.clk(clk), .wr(mem_wr), .addr(mem_addr), .wdata(mem_wdata),
    .rd(mem_rd), .raddr(mem_raddr), .erase(mem_erase), .corrupt(corrupt),
    .rdata(mem_rdata));

  // 100 MHz system clock
  always #5 clk = ~clk;

  // pulse monitor; the suspend cell is written only by the sequencer's strobe
  always @(posedge clk)
  begin
    if (sec_wr)
    begin
      sec_at = wr_n;
      sec_cap = sec_data;
    end
    if (mem_wr)
    begin
      wr_n++;
      addr_q.push_back(mem_addr);
    end
    er_n += int'(mem_erase);
    dr_n += int'(dev_reset);
    dn_n += int'(prog_done);
    pe_n += int'(prog_err);
    sv_n += int'(svc_ack);
    tf_n += int'(t_flag);
    tr_n += int'(t_rst);
    tz_n += int'(t_zero);
    if (nv_wr)
      nv_cell <= nv_wdata;
  end

  task stop_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // a bound that runs out ends the run as a failure
  task tmo();
    err_count++;
    $display("MISMATCH t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    stop_test();
  endtask

  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // request held until the ready seen at a negedge is sampled at the next posedge
  task send_cmd(input logic [7:0] o, input logic [2:0] s);
    int i;
    op = o;
    src = s;
    cmd_valid = 1'b1;
    for (i = 0; i < 200 && cmd_ready !== 1'b1; i++) @(negedge clk);
    if (i == 200) tmo();
    @(negedge clk);
    cmd_valid = 1'b0;
  endtask

  task send_blk(input logic [BUF_W-1:0] d, input logic l);
    int i;
    bdata = d;
    buf_last = l;
    buf_valid = 1'b1;
    for (i = 0; i < 200 && buf_ready !== 1'b1; i++) @(negedge clk);
    if (i == 200) tmo();
    @(negedge clk);
    buf_valid = 1'b0;
    bdata = ~d; // no stale block left on the bus
    @(negedge clk); // an edge passes before the next block raises valid again
  endtask

  task wait_held(input logic v);
    int i;
    for (i = 0; i < 200 && held !== v; i++) @(negedge clk);
    if (i == 200) tmo();
  endtask

  function automatic logic [31:0] fold(input logic [BUF_W-1:0] b);
    return b[31:0] ^ b[63:32] ^ b[95:64] ^ b[127:96];
  endfunction

  task run_prog(input logic [1:0] fl, input logic bad_dig, input logic bad_mem);
    logic [BUF_W-1:0] b0, b1, hdr;
    logic [CNT_W-1:0] c0;
    int w0, d0, e0, r0, i;
    logic ok;
    b0 = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;
    b1 = 128'hdead_0001_5a5a_a5a5_0f0f_f0f0_1357_2468;
    hdr = {fold(b0) ^ fold(b1) ^ {31'h0, bad_dig}, 56'h0, 32'h5ec0_a11b, 6'h0, fl};
    w0 = wr_n;
    d0 = dn_n;
    e0 = pe_n;
    r0 = dr_n;
    c0 = count;
    ok = !bad_dig && !bad_mem;
    corrupt = bad_mem;
    addr_q.delete();
    send_cmd(OP_PROGRAM, SRC_JTAG);
    send_blk(hdr, 1'b0);
    send_blk(b0, 1'b0);
    send_blk(b1, 1'b1);
    for (i = 0; i < 200 && dn_n == d0 && pe_n == e0; i++) @(negedge clk);
    if (i == 200) tmo();
    corrupt = 1'b0;
    @(negedge clk);
    `CHK(wr_n - w0, 2)
    `CHK({addr_q[0], addr_q[1]}, 32'h0000_0001)
    `CHK(dr_n - r0, int'(ok))
    `CHK(pe_n - e0, int'(!ok))
    if (ok)
    begin
      `CHK(count, c0 + 16'h0002)
      `CHK(sec_cap, hdr[39:8])
      `CHK(sec_at - w0, fl[0] ? 0 : 2)
      `CHK(nv_cell, fl[1])
    end
    $display("program run %b %b %b done", fl, bad_dig, bad_mem);
  endtask

  // services and tamper answers, exp is 1 when they must be served
  task svc_tamper(input int exp);
    int s0, f0, r0, z0;
    s0 = sv_n;
    f0 = tf_n;
    r0 = tr_n;
    z0 = tz_n;
    svc_req = 1'b1;
    cyc(3);
    svc_req = 1'b0;
    for (int z = 0; z < 2; z++)
    begin
      zsel = z[0];
      tamper_evt = 1'b1;
      @(negedge clk);
      tamper_evt = 1'b0;
      cyc(3);
    end
    `CHK(sv_n - s0, 3 * exp)
    `CHK(tf_n - f0, 2 * exp)
    `CHK(tr_n - r0, exp)
    `CHK(tz_n - z0, exp)
    $display("service and tamper %0d done", exp);
  endtask

  // main sequence: table rows first, then the hand-written cases
  initial
  begin
    int e0;
    logic [CNT_W-1:0] c0;
    {cmd_valid, buf_valid, buf_last, svc_req, tamper_evt, zsel, scan_mode, tdi} = 8'h00;
    op = 8'h00;
    src = 3'h0;
    hi = 3'h0;
    bdata = {BUF_W{1'b0}};
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      {scan_mode, tdi, hi} = scan_rows[i][8:4];
      @(negedge clk);
      `CHK(scan_bus, scan_rows[i][3:0])
    end
    $display("scan rows done");
    for (int i = 0; i < 7; i++)
    begin
      if (i == 6)
      begin
        role = 1'b1; // late role change must not take effect
        cyc(6); // let the new level clear the pin filter first
      end
      e0 = er_n;
      c0 = count;
      send_cmd(cmd_rows[i % 6][11:4], i == 6 ? SRC_SPI_SLAVE : cmd_rows[i % 6][3:1]);
      cyc(6);
      `CHK(er_n - e0, i == 6 ? 1 : int'(cmd_rows[i % 6][0]))
      `CHK(count, c0 + {15'h0, (i == 6) | cmd_rows[i % 6][0]})
    end
    role = 1'b0;
    $display("command rows done");
    svc_tamper(1);
    run_prog(2'b01, 1'b0, 1'b0);
    run_prog(2'b00, 1'b0, 1'b0);
    run_prog(2'b00, 1'b1, 1'b0);
    run_prog(2'b00, 1'b0, 1'b1);
    run_prog(2'b10, 1'b0, 1'b0);
    wait_held(1'b1);
    `CHK(held, 1'b1)
    e0 = er_n;
    c0 = count;
    send_cmd(OP_ERASE, SRC_JTAG);
    cyc(6);
    `CHK(er_n - e0, 0)
    `CHK(count, c0)
    svc_tamper(0);
    role = 1'b1; // master role latched at the coming reset
    rst_n = 1'b0;
    cyc(2);
    rst_n = 1'b1;
    @(negedge clk);
    `CHK(held, 1'b0)
    wait_held(1'b1);
    `CHK(held, 1'b1)
    $display("suspend entry done");
    rel = 1'b1;
    wait_held(1'b0);
    `CHK(held, 1'b0)
    e0 = er_n;
    c0 = count;
    send_cmd(OP_ERASE, SRC_SPI_MASTER);
    cyc(6);
    `CHK(er_n - e0, 0)
    `CHK(count, c0)
    svc_tamper(0);
    run_prog(2'b00, 1'b0, 1'b0);
    rel = 1'b0;
    cyc(30);
    `CHK(held, 1'b0)
    e0 = er_n;
    send_cmd(OP_ERASE, SRC_AUTO_UPDATE);
    cyc(6);
    `CHK(er_n - e0, 1)
    $display("suspend release done");
    stop_test();
  end
endmodule
